// file: hdl/vecarb_rank.sv
// Fixed-rank priority encoder producing the vector table code.
`timescale 1ns/100ps
`default_nettype none
`include "vecarb_consts.svh"
module vecarb_rank
	import vecarb_pkg::*;
(
	// Sources
	input wire logic trap_i,
	input wire vecarb_src_s active_i,
	// Code
	output logic [7:0] code_o
);
	// Chain ordered from highest rank down; reserved codes never appear.
	assign code_o = trap_i ? `VA_CODE_TRAP :
		active_i.ext ? `VA_CODE_EXT :
		active_i.idle_timer ? `VA_CODE_IDLE :
		active_i.t1a ? `VA_CODE_T1A :
		active_i.t1b ? `VA_CODE_T1B :
		active_i.ser ? `VA_CODE_SER :
		active_i.t2a ? `VA_CODE_T2A :
		active_i.t2b ? `VA_CODE_T2B :
		active_i.portl ? `VA_CODE_PORTL :
		`VA_CODE_DEFAULT;
endmodule
`default_nettype wire

// file: hdl/vecarb_top.sv
// Vectored interrupt arbiter with software trap pending flag and vector dispatch.
`timescale 1ns/100ps
`default_nettype none
`include "vecarb_consts.svh"
module vecarb_top
	import vecarb_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	// Maskable sources from peripheral registers
	input wire vecarb_src_s SRC_EN_I,
	input wire vecarb_src_s SRC_PEND_I,
	input wire logic GLOBAL_INT_EN_I,
	// Sequencer events
	input wire logic INSTR_START_I,
	input wire logic [7:0] OPCODE_I,
	input wire logic DISPATCH_I,
	input wire logic CLEAR_TRAP_I,
	input wire logic RET_I,
	input wire logic [7:0] STACK_PTR_I,
	input wire logic [14:0] PC_I,
	input wire logic [14:0] NEXT_PC_I,
	// Program memory
	input wire logic [7:0] PMEM_DATA_I,
	input wire logic PMEM_VALID_I,
	input wire logic PMEM_EXISTS_I,
	// Results
	output logic [7:0] FETCH_DATA_O,
	output logic TRAP_PENDING_O,
	output logic ACK_BUSY_O,
	output logic CLEAR_GIE_O,
	output logic PUSH_O,
	output logic [14:0] PUSH_ADDR_O,
	output logic PC_LOAD_O,
	output logic [14:0] PC_NEW_O,
	output logic PMEM_REQ_O,
	output logic [14:0] PMEM_ADDR_O,
	output logic [7:0] DISPATCH_CODE_O,
	output logic DISPATCH_DONE_O
);
	vecarb_state_e state_r, state_nxt;
	logic trap_pend_r;
	logic [2:0] ack_cnt_r;
	logic [7:0] code_r;
	logic [14:0] table_base_r;
	logic [6:0] vec_hi_r;
	logic push_r;
	logic [14:0] push_addr_r;
	logic pc_load_r;
	logic [14:0] pc_new_r;
	logic done_r;
	logic clear_gie_r;

	vecarb_src_s active;
	logic [7:0] code;
	logic [7:0] mem_byte;
	logic trap_fetch;
	logic maskable_req;
	logic underflow;
	logic [14:0] table_page;

	// Absent locations read as zero so a runaway fetch decodes a trap.
	assign mem_byte = PMEM_EXISTS_I ? PMEM_DATA_I : 8'h00;
	assign FETCH_DATA_O = mem_byte;
	// Trap fires on any fetch of the zero opcode, whatever its cause.
	assign trap_fetch = INSTR_START_I && (OPCODE_I == `VA_TRAP_OPCODE);

	// Enabled plus pending; trap flag masks every maskable source.
	assign active = vecarb_src_s'(SRC_EN_I & SRC_PEND_I);
	assign maskable_req = (|active) && GLOBAL_INT_EN_I && !trap_pend_r;

	vecarb_rank u_rank (
		.trap_i(trap_pend_r),
		.active_i(active),
		.code_o(code)
	);

	// Dispatch at a page's last byte points into the following page.
	assign table_page = (PC_I[7:0] == `VA_PAGE_LAST) ?
		(PC_I + 15'h0100) : PC_I;
	assign underflow = RET_I && (STACK_PTR_I == `VA_STACK_LIMIT);

	// Flag: reset clears, trap sets, clear instruction clears; set wins.
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			trap_pend_r <= 1'b0;
		end else if (trap_fetch) begin
			trap_pend_r <= 1'b1;
		end else if (CLEAR_TRAP_I) begin
			trap_pend_r <= 1'b0;
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			VA_IDLE: begin
				if (trap_fetch || (INSTR_START_I && maskable_req)) begin
					state_nxt = VA_ACK;
				end else if (DISPATCH_I) begin
					state_nxt = VA_VEC_HI;
				end
			end
			VA_ACK: begin
				if (ack_cnt_r == `VA_ACK_CYCLES - 3'h1) begin
					state_nxt = VA_IDLE;
				end
			end
			VA_VEC_HI: begin
				if (PMEM_VALID_I) begin
					state_nxt = VA_VEC_LO;
				end
			end
			VA_VEC_LO: begin
				if (PMEM_VALID_I) begin
					state_nxt = VA_IDLE;
				end
			end
			default: begin
				state_nxt = VA_IDLE;
			end
		endcase
	end

	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_r <= VA_IDLE;
			ack_cnt_r <= 3'h0;
		end else begin
			state_r <= state_nxt;
			ack_cnt_r <= (state_r == VA_ACK) ? ack_cnt_r + 3'h1 : 3'h0;
		end
	end

	// Dispatch captures code and page in its first cycle.
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			code_r <= `VA_CODE_DEFAULT;
			table_base_r <= 15'h0000;
		end else if (state_r == VA_IDLE && state_nxt == VA_VEC_HI) begin
			code_r <= code;
			table_base_r <= {table_page[14:8], code};
		end
	end

	// Vector high byte sits at the even address, low byte follows.
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			vec_hi_r <= 7'h00;
		end else if (state_r == VA_VEC_HI && PMEM_VALID_I) begin
			vec_hi_r <= mem_byte[6:0];
		end
	end

	assign PMEM_REQ_O = (state_r == VA_VEC_HI) || (state_r == VA_VEC_LO);
	assign PMEM_ADDR_O = (state_r == VA_VEC_LO) ?
		{table_base_r[14:1], 1'b1} : table_base_r;

	// Acknowledge: trap pushes its own address, maskable the next one.
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			push_r <= 1'b0;
			push_addr_r <= 15'h0000;
			clear_gie_r <= 1'b0;
			pc_load_r <= 1'b0;
			pc_new_r <= 15'h0000;
			done_r <= 1'b0;
		end else begin
			push_r <= 1'b0;
			clear_gie_r <= 1'b0;
			pc_load_r <= 1'b0;
			done_r <= 1'b0;
			if (state_r == VA_IDLE && state_nxt == VA_ACK) begin
				push_r <= 1'b1;
				push_addr_r <= trap_fetch ? PC_I : NEXT_PC_I;
				clear_gie_r <= !trap_fetch;
				pc_load_r <= 1'b1;
				pc_new_r <= `VA_ACK_PC;
			end else if (state_r == VA_VEC_LO && PMEM_VALID_I) begin
				pc_load_r <= 1'b1;
				pc_new_r <= {vec_hi_r, mem_byte};
				done_r <= 1'b1;
			end else if (state_r == VA_IDLE && underflow) begin
				pc_load_r <= 1'b1;
				pc_new_r <= `VA_UNDERFLOW_PC;
			end
		end
	end

	// Flag has no address; it leaves only on TRAP_PENDING_O for the sequencer.
	assign TRAP_PENDING_O = trap_pend_r;
	assign ACK_BUSY_O = (state_r == VA_ACK);
	assign CLEAR_GIE_O = clear_gie_r;
	assign PUSH_O = push_r;
	assign PUSH_ADDR_O = push_addr_r;
	assign PC_LOAD_O = pc_load_r;
	assign PC_NEW_O = pc_new_r;
	assign DISPATCH_CODE_O = code_r;
	assign DISPATCH_DONE_O = done_r;
endmodule
`default_nettype wire

// file: shared/vecarb_consts.svh
// Constants of the vectored interrupt arbiter.
// Behaviour
// - Highest fixed rank wins among active sources
// - After return, next highest pending wins
// - Dispatch samples sources in first cycle
// - Fixed code per source, trap FE
// - No active source yields default E0
// - Code replaces only PC low byte (page advances when PC low byte is FF)
// - Vector fetched from table loads PC
// - Trap pending flag has no address
// - Reset clears flag, trap sets it
// - Clear-trap instruction alone clears flag
// - Fetched zero opcode raises software trap
// - Unused program memory reads zero
// - Stack underflow loads PC 7FFF
// - Trap keeps global enable, blocks maskables
// - Only another trap interrupts trap routine
// - Trap pushes address of trap opcode
// - Trap opcode is all-zero byte
// - Vector high byte at even address
// - Active means enabled and pending both
// - Acknowledge pushes, jumps 00FF; maskable one also clears enable
`ifndef VECARB_CONSTS_SVH
`define VECARB_CONSTS_SVH
`define VA_CODE_TRAP 8'hfe
`define VA_CODE_EXT 8'hfa
`define VA_CODE_IDLE 8'hf8
`define VA_CODE_T1A 8'hf6
`define VA_CODE_T1B 8'hf4
`define VA_CODE_SER 8'hf2
`define VA_CODE_T2A 8'hea
`define VA_CODE_T2B 8'he8
`define VA_CODE_PORTL 8'he2
`define VA_CODE_DEFAULT 8'he0
`define VA_TRAP_OPCODE 8'h00
`define VA_ACK_PC 15'h00ff
`define VA_UNDERFLOW_PC 15'h7fff
`define VA_STACK_LIMIT 8'h6f
`define VA_ACK_CYCLES 3'h7
`define VA_PAGE_LAST 8'hff
`endif

// file: shared/vecarb_pkg.sv
// Types of the vectored interrupt arbiter.
package vecarb_pkg;
	typedef enum logic [3:0] {
		VA_IDLE = 4'b0001,
		VA_ACK = 4'b0010,
		VA_VEC_HI = 4'b0100,
		VA_VEC_LO = 4'b1000
	} vecarb_state_e;
	typedef struct packed {
		logic ext;
		logic idle_timer;
		logic t1a;
		logic t1b;
		logic ser;
		logic t2a;
		logic t2b;
		logic portl;
	} vecarb_src_s;
	typedef struct packed {
		logic req;
		logic [14:0] addr;
	} vecarb_fetch_s;
endpackage

// file: verification/vecarb_bench.sv
// Self-checking bench for the vectored interrupt arbiter.
`timescale 1ns/100ps
`default_nettype none
module vecarb_bench
	import vecarb_pkg::*;
;
	logic CORE_CLK_I = 1'b0, RST_N_I = 1'b0, INSTR_START_I = 1'b0, DISPATCH_I = 1'b0;
	logic CLEAR_TRAP_I = 1'b0, RET_I = 1'b0, GLOBAL_INT_EN_I = 1'b0, PMEM_VALID_I, PMEM_EXISTS_I;
	logic [7:0] OPCODE_I = 8'h01, STACK_PTR_I = 8'h20, PMEM_DATA_I, FETCH_DATA_O, DISPATCH_CODE_O;
	logic [14:0] PC_I = '0, NEXT_PC_I = '0, PUSH_ADDR_O, PC_NEW_O, PMEM_ADDR_O;
	logic TRAP_PENDING_O, ACK_BUSY_O, CLEAR_GIE_O, PUSH_O, PC_LOAD_O, PMEM_REQ_O, DISPATCH_DONE_O;
	vecarb_src_s SRC_EN_I = '0, SRC_PEND_I = '0;
	logic [23:0] exp_q[$];
	logic [31:0] rng = 32'h62eb;
	int bad_count = 0, samples_checked = 0, n;
	logic [7:0] codes [9] = '{8'hfa, 8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'hea, 8'he8, 8'he2, 8'he0};
	always #50 CORE_CLK_I = ~CORE_CLK_I;
	vecarb_top uut (.*);
	vecarb_pmem_model far (.clk_i(CORE_CLK_I), .req_i(PMEM_REQ_O), .addr_i(PMEM_ADDR_O),
		.valid_o(PMEM_VALID_I), .exists_o(PMEM_EXISTS_I), .data_o(PMEM_DATA_I));
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		return x ^ (x << 5);
	endfunction
	function automatic logic [7:0] mem(input logic [14:0] a);
		return a[14] ? 8'h00 : a[7:0] ^ 8'h3c;
	endfunction
	task automatic check(input logic [23:0] seen, input logic [23:0] want);
		samples_checked++;
		if (seen !== want) begin
			bad_count++;
			$display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic end_of_test();
		$display("compared %0d mismatched %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Bits of k: start, dispatch, clear, return; each pulse lasts one cycle.
	task automatic pulse(input logic [3:0] k, input logic [7:0] op);
		@(posedge CORE_CLK_I);
		{INSTR_START_I, DISPATCH_I, CLEAR_TRAP_I, RET_I} <= k;
		OPCODE_I <= op;
		@(posedge CORE_CLK_I);
		{INSTR_START_I, DISPATCH_I, CLEAR_TRAP_I, RET_I} <= 4'h0;
		#1;
		for (n = 0; n < 40 && (ACK_BUSY_O || PMEM_REQ_O); n++) begin
			@(posedge CORE_CLK_I);
			#1;
		end
		if (n == 40) begin
			bad_count++;
			end_of_test();
		end
		@(posedge CORE_CLK_I);
	endtask
	task automatic disp(input logic [14:0] pc, input logic [7:0] code);
		logic [14:0] a;
		logic [7:0] hi;
		PC_I <= pc;
		a = {pc[7:0] == 8'hff ? pc[14:8] + 7'h1 : pc[14:8], code};
		hi = mem(a);
		exp_q.push_back({1'b0, code, hi[6:0], mem(a | 15'h1)});
		pulse(4'b0100, 8'h01);
	endtask
	always @(posedge CORE_CLK_I) begin
		if (DISPATCH_DONE_O) check({1'b0, DISPATCH_CODE_O, PC_NEW_O}, exp_q.pop_front());
		if (PUSH_O) check({1'b1, 7'h00, CLEAR_GIE_O, PUSH_ADDR_O}, exp_q.pop_front());
		if (PUSH_O) check({7'h00, PC_LOAD_O, 1'b0, PC_NEW_O}, 24'h0100ff);
		if (PC_LOAD_O && !PUSH_O && !DISPATCH_DONE_O) check({9'h000, PC_NEW_O}, 24'h007fff);
	end
	initial begin
		repeat (4) @(posedge CORE_CLK_I);
		RST_N_I <= 1'b1;
		check({7'h0, TRAP_PENDING_O, 8'h00, DISPATCH_CODE_O}, 24'h0000e0);
		for (int i = 0; i < 9; i++) begin
			rng = xs(rng);
			SRC_EN_I <= (rng[7:0] & (8'hff >> i)) | (8'h80 >> i) | (rng[15:8] & ~(8'hff >> i));
			SRC_PEND_I <= (rng[23:16] & (8'hff >> i)) | (8'h80 >> i);
			disp({rng[30:24], i == 3 ? 8'hff : rng[7:0]}, codes[i]);
		end
		$display("dispatch ranking finished");
		GLOBAL_INT_EN_I <= 1'b1;
		SRC_EN_I <= 8'hff;
		SRC_PEND_I <= 8'hc0;
		NEXT_PC_I <= rng[14:0];
		exp_q.push_back({9'h101, rng[14:0]});
		pulse(4'b1000, 8'h01);
		disp(rng[14:0], 8'hfa);
		SRC_PEND_I <= 8'h40;
		disp(rng[14:0], 8'hf8);
		$display("maskable entry finished");
		PC_I <= rng[29:15];
		exp_q.push_back({9'h100, rng[29:15]});
		pulse(4'b1000, 8'h00);
		check({23'h0, TRAP_PENDING_O}, 24'h000001);
		pulse(4'b1000, 8'h01);
		disp(rng[29:15], 8'hfe);
		pulse(4'b0010, 8'h01);
		check({23'h0, TRAP_PENDING_O}, 24'h000000);
		STACK_PTR_I <= 8'h6f;
		pulse(4'b0001, 8'h01);
		$display("trap handling finished");
		end_of_test();
	end
endmodule
`default_nettype wire

// file: verification/vecarb_pmem_model.sv
// Program memory stand-in answering vector fetches on alternate cycles.
`timescale 1ns/100ps
`default_nettype none
module vecarb_pmem_model (
	// Request
	input wire logic clk_i,
	input wire logic req_i,
	input wire logic [14:0] addr_i,
	// Answer
	output logic valid_o,
	output logic exists_o,
	output logic [7:0] data_o
);
	wire [7:0] byte_w = addr_i[7:0] ^ 8'h3c;
	assign exists_o = !addr_i[14];
	// Between answers the inverse is shown so a stale byte cannot pass.
	assign data_o = valid_o ? byte_w : ~byte_w;
	initial valid_o = 1'b0;
	always @(posedge clk_i) valid_o <= req_i && !valid_o;
endmodule
`default_nettype wire

// file: verification/vecarb_props.sv
// Port assertions for the vectored interrupt arbiter.
`timescale 1ns/100ps
`default_nettype none
module vecarb_props
	import vecarb_pkg::*;
(
	input wire logic CORE_CLK_I, RST_N_I, INSTR_START_I, GLOBAL_INT_EN_I, CLEAR_TRAP_I, RET_I,
	input wire logic PMEM_EXISTS_I, TRAP_PENDING_O, ACK_BUSY_O, CLEAR_GIE_O, PUSH_O, PC_LOAD_O,
	input wire logic PMEM_REQ_O, DISPATCH_DONE_O,
	input wire logic [7:0] OPCODE_I, STACK_PTR_I, FETCH_DATA_O, DISPATCH_CODE_O,
	input wire logic [14:0] PC_I, NEXT_PC_I, PUSH_ADDR_O, PC_NEW_O, PMEM_ADDR_O,
	input wire vecarb_src_s SRC_EN_I, SRC_PEND_I
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);
	wire idle = !ACK_BUSY_O && !PMEM_REQ_O;
	wire trap = INSTR_START_I && OPCODE_I == 8'h00;
	trap_flag_a: assert property (trap && idle |=> TRAP_PENDING_O)
		else $error("trap flag not set");
	trap_entry_a: assert property (trap && idle |=> PUSH_O && !CLEAR_GIE_O && PC_LOAD_O
		&& PUSH_ADDR_O == $past(PC_I) && PC_NEW_O == 15'h00ff) else $error("trap entry wrong");
	mask_entry_a: assert property (INSTR_START_I && OPCODE_I != 8'h00 && idle
		&& GLOBAL_INT_EN_I && !TRAP_PENDING_O && |(SRC_EN_I & SRC_PEND_I) |=> PUSH_O
		&& CLEAR_GIE_O && PUSH_ADDR_O == $past(NEXT_PC_I)) else $error("maskable entry wrong");
	mask_block_a: assert property (TRAP_PENDING_O && !trap |=> !PUSH_O)
		else $error("maskable taken under trap");
	flag_hold_a: assert property (TRAP_PENDING_O && !CLEAR_TRAP_I |=> TRAP_PENDING_O)
		else $error("trap flag lost");
	flag_clear_a: assert property (CLEAR_TRAP_I && !trap |=> !TRAP_PENDING_O)
		else $error("trap flag kept");
	ack_length_a: assert property ($rose(ACK_BUSY_O) |-> ACK_BUSY_O [*7] ##1 !ACK_BUSY_O)
		else $error("acknowledge length wrong");
	underflow_pc_a: assert property (RET_I && STACK_PTR_I == 8'h6f && idle
		|=> PC_LOAD_O && PC_NEW_O == 15'h7fff) else $error("underflow load wrong");
	vector_addr_a: assert property ($rose(PMEM_REQ_O) |-> PMEM_ADDR_O[7:0] == DISPATCH_CODE_O)
		else $error("vector address wrong");
	reserved_code_a: assert property (DISPATCH_DONE_O |-> !(DISPATCH_CODE_O inside
		{8'hfc, 8'hf0, 8'hee, 8'hec, 8'he6, 8'he4})) else $error("reserved code produced");
	absent_zero_a: assert property (!PMEM_EXISTS_I |-> FETCH_DATA_O == 8'h00)
		else $error("absent location not zero");
	cover property (trap && idle);
	cover property (DISPATCH_DONE_O && DISPATCH_CODE_O == 8'he0);
	cover property (RET_I && STACK_PTR_I == 8'h6f);
endmodule
bind vecarb_top vecarb_props chk (.*);
`default_nettype wire
